// [core/intc_regs.svh]
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define OFF_CTL 8'h00
`define OFF_PACE 8'h04
`define OFF_VECTOR 8'h08
`define OFF_SRC_EN 8'h0c
`define OFF_RX_SHUT 8'h10
`define OFF_TX_SHUT 8'h14
`define OFF_ERR 8'h18
`define OFF_ACK_BASE 8'h20
`define OFF_ACK_LAST 8'h5c
`define OFF_STAT_BASE 8'h80
`define OFF_STAT_LAST 8'hbc

// Control word field positions
`define CTL_COMBINED_INTERRUPT_ENABLE_BIT 0
`define CTL_MDIORST_BIT 1
`define CTL_MACRST_BIT 2

// Reset values
`define CTL_RESET 3'h0
`define PACE_RESET 17'h0_0000
`define SRC_EN_RESET 20'h0_0000

// Pace counter and teardown completion
`define PACE_W 17
`define TEARDOWN_CODE 32'hffff_fffc

// Peripheral clock is the system clock divided by this ratio
`define PERIPH_DIV 4

`endif

// [core/intc_pkg.sv]
package intc_pkg;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [31:0] desc;
  } chan_event_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
  } chan_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
  } stat_inc_t;

  typedef struct packed {
    logic mdio_done;
    logic link_change;
    logic counter_ovf;
    logic host_err;
    logic [7:0] tx;
    logic [7:0] rx;
  } source_vector_t;

endpackage

// [core/stat_counter_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module stat_counter_mem (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire intc_pkg::stat_inc_t stat_inc,
  input wire logic dec_valid,
  input wire logic [3:0] dec_index,
  input wire logic [31:0] dec_value,
  input wire logic [3:0] rd_index,
  output logic [31:0] rd_data,
  output logic [15:0] msb_flags
);
  import intc_pkg::*;

  logic [31:0] mem [16];

  wire same_word = stat_inc.valid && dec_valid && (stat_inc.idx == dec_index);
  wire [31:0] inc_word = mem[stat_inc.idx] + 32'h0000_0001;
  // A hardware count landing on the word being decremented is kept, not lost
  wire [31:0] dec_word = mem[dec_index] - dec_value + {31'h0, same_word};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 32'h0000_0000;
      end
      rd_data <= 32'h0000_0000;
    end else begin
      if (stat_inc.valid && !same_word) begin
        mem[stat_inc.idx] <= inc_word;
      end
      if (dec_valid) begin
        mem[dec_index] <= dec_word;
      end
      rd_data <= mem[rd_index];
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      msb_flags[i] = mem[i][31];
    end
  end

endmodule
`default_nettype wire

// [core/mac_interrupt_combiner_pacing.sv]
// Operation
// - Raise the MDIO-done source when a PHY register access finishes.
// - Raise the link-change source when a monitored PHY link state changes.
// - Raise host-error pending on a host-caused MAC error; status is readable.
// - Raise counter-overflow pending while any statistics counter has its MSB set.
// - One receive pending flag per each of eight receive channels.
// - One transmit pending flag per each of eight transmit channels.
// - One read of the source vector returns every enabled source flag together.
// - Clearing the combined enable drops the interrupt output at once.
// - Re-enabling with enabled sources pending drives the output high again.
// - Each disable-then-enable reloads and restarts the pace counter.
// - Pace zero rearms at once; nonzero waits that many peripheral cycles.
// - Pace counter decrements once per peripheral cycle, system clock over four.
// - Writing a statistics counter subtracts the written value from it.
// - Software requests channel teardown; the device winds that channel down.
// - After teardown finishes, the channel ack register reads the completion code.
// - After a host error halts the MAC, teardowns never complete.
// - Ack register shows last descriptor; writing it back acknowledges the channel.
// - The vector shows only sources whose individual enables are set.
// - The pace count is 17 bits and resets to zero, inactive.
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
module mac_interrupt_combiner_pacing (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mdio_access_done_event,
  input wire logic link_change_event,
  input wire logic host_error_event,
  input wire logic [31:0] mac_error_code,
  input wire intc_pkg::chan_event_t rx_desc_event,
  input wire intc_pkg::chan_event_t tx_desc_event,
  input wire intc_pkg::chan_req_t rx_shutdown_done,
  input wire intc_pkg::chan_req_t tx_shutdown_done,
  input wire intc_pkg::stat_inc_t stat_inc,
  output var intc_pkg::chan_req_t rx_shutdown_cmd,
  output var intc_pkg::chan_req_t tx_shutdown_cmd,
  output logic mac_reset,
  output logic mdio_reset,
  output logic mac_halted,
  output logic irq_out
);
  import intc_pkg::*;

  function automatic logic [3:0] word_index(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return diff[5:2];
  endfunction

  function automatic logic in_window(input logic [7:0] addr, input logic [7:0] lo,
                                     input logic [7:0] hi);
    return (addr >= lo) && (addr <= hi) && (addr[1:0] == 2'b00);
  endfunction

  // Control and configuration state
  logic int_enable;
  logic [`PACE_W-1:0] pace_count;
  logic [`PACE_W-1:0] pace_cnt;
  logic [1:0] presc;
  source_vector_t src_enable;
  logic mdio_done_flag;
  logic link_flag;
  logic host_err_flag;
  logic [31:0] err_status;
  logic [15:0] chan_pend;
  logic [31:0] chan_ack [16];
  logic [31:0] rdata_q;
  logic rd_stat_q;
  logic [31:0] stat_rdata;
  logic [15:0] stat_msb;

  // Address decode
  wire wr_ctl = reg_wr && (reg_addr == `OFF_CTL);
  wire wr_pace = reg_wr && (reg_addr == `OFF_PACE);
  wire wr_vector = reg_wr && (reg_addr == `OFF_VECTOR);
  wire wr_src_en = reg_wr && (reg_addr == `OFF_SRC_EN);
  wire wr_rx_shut = reg_wr && (reg_addr == `OFF_RX_SHUT);
  wire wr_tx_shut = reg_wr && (reg_addr == `OFF_TX_SHUT);
  wire ack_sel = in_window(reg_addr, `OFF_ACK_BASE, `OFF_ACK_LAST);
  wire stat_sel = in_window(reg_addr, `OFF_STAT_BASE, `OFF_STAT_LAST);
  wire [3:0] ack_index = word_index(reg_addr, `OFF_ACK_BASE);
  wire [3:0] stat_index = word_index(reg_addr, `OFF_STAT_BASE);

  // Raw sources before the individual enables
  source_vector_t raw_src;
  source_vector_t vector;
  assign raw_src.mdio_done = mdio_done_flag;
  assign raw_src.link_change = link_flag;
  assign raw_src.counter_ovf = |stat_msb;
  assign raw_src.host_err = host_err_flag;
  assign raw_src.tx = chan_pend[15:8];
  assign raw_src.rx = chan_pend[7:0];
  // A source masked at its own enable never shows in the vector
  assign vector = raw_src & src_enable;

  wire any_pending = |vector;
  wire en_rise = wr_ctl && reg_wdata[`CTL_COMBINED_INTERRUPT_ENABLE_BIT] && !int_enable;
  wire pace_tick = (presc == 2'(`PERIPH_DIV - 1));

  // Combinational so that a disable takes the line low in the cycle after the write
  assign irq_out = int_enable && (pace_cnt == '0) && any_pending;
  assign mac_halted = host_err_flag;

  // Control word; enable, MDIO reset and MAC reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {mac_reset, mdio_reset, int_enable} <= `CTL_RESET;
    end else if (wr_ctl) begin
      int_enable <= reg_wdata[`CTL_COMBINED_INTERRUPT_ENABLE_BIT];
      mdio_reset <= reg_wdata[`CTL_MDIORST_BIT];
      mac_reset <= reg_wdata[`CTL_MACRST_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pace_count <= `PACE_RESET;
      src_enable <= `SRC_EN_RESET;
    end else begin
      if (wr_pace) begin
        pace_count <= reg_wdata[`PACE_W-1:0];
      end
      if (wr_src_en) begin
        src_enable <= reg_wdata[$bits(source_vector_t)-1:0];
      end
    end
  end

  // Pace counter: reloaded on each enable rise, then counts peripheral cycles
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pace_cnt <= '0;
      presc <= 2'h0;
    end else if (en_rise) begin
      pace_cnt <= pace_count;
      presc <= 2'h0;
    end else if (pace_cnt != '0) begin
      presc <= presc + 2'h1;
      if (pace_tick) begin
        pace_cnt <= pace_cnt - `PACE_W'(1);
      end
    end
  end

  // MDIO-done and link-change sources; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst || mdio_reset) begin
      mdio_done_flag <= 1'b0;
      link_flag <= 1'b0;
    end else begin
      mdio_done_flag <= mdio_access_done_event ||
                        (mdio_done_flag && !(wr_vector && reg_wdata[19]));
      link_flag <= link_change_event ||
                   (link_flag && !(wr_vector && reg_wdata[18]));
    end
  end

  // Host error halts the MAC until software resets it
  always_ff @(posedge clk_sys) begin
    if (!nrst || mac_reset) begin
      host_err_flag <= 1'b0;
      err_status <= 32'h0000_0000;
    end else if (host_error_event) begin
      host_err_flag <= 1'b1;
      err_status <= mac_error_code;
    end
  end

  // Per-channel pending flags and ack words; index 0-7 receive, 8-15 transmit
  logic [15:0] desc_hit;
  logic [15:0] done_hit;
  logic [15:0] ack_clear;
  logic [31:0] desc_word [16];
  generate
    for (genvar j = 0; j < 16; j++) begin : g_chan
      localparam logic [2:0] CH = 3'(j % 8);
      if (j < 8) begin : g_rx
        assign desc_hit[j] = rx_desc_event.valid && (rx_desc_event.chan == CH);
        // Teardown completions are dropped once the MAC has halted
        assign done_hit[j] = rx_shutdown_done.valid && (rx_shutdown_done.chan == CH)
                             && !host_err_flag;
        assign desc_word[j] = rx_desc_event.desc;
      end else begin : g_tx
        assign desc_hit[j] = tx_desc_event.valid && (tx_desc_event.chan == CH);
        assign done_hit[j] = tx_shutdown_done.valid && (tx_shutdown_done.chan == CH)
                             && !host_err_flag;
        assign desc_word[j] = tx_desc_event.desc;
      end
      // Write back of the shown value acknowledges the channel
      assign ack_clear[j] = reg_wr && ack_sel && (ack_index == 4'(j))
                            && (reg_wdata == chan_ack[j]);
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!nrst || mac_reset) begin
      chan_pend <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        chan_ack[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        chan_pend[i] <= desc_hit[i] || done_hit[i] ||
                        (chan_pend[i] && !ack_clear[i]);
        if (done_hit[i]) begin
          chan_ack[i] <= `TEARDOWN_CODE;
        end else if (desc_hit[i]) begin
          chan_ack[i] <= desc_word[i];
        end
      end
    end
  end

  // Teardown requests go to the DMA engines as one-cycle commands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_shutdown_cmd <= '0;
      tx_shutdown_cmd <= '0;
    end else begin
      rx_shutdown_cmd.valid <= wr_rx_shut;
      rx_shutdown_cmd.chan <= reg_wdata[2:0];
      tx_shutdown_cmd.valid <= wr_tx_shut;
      tx_shutdown_cmd.chan <= reg_wdata[2:0];
    end
  end

  // Statistics counters
  stat_counter_mem u_stats (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .stat_inc(stat_inc),
    .dec_valid(reg_wr && stat_sel),
    .dec_index(stat_index),
    .dec_value(reg_wdata),
    .rd_index(stat_index),
    .rd_data(stat_rdata),
    .msb_flags(stat_msb)
  );

  // Read side
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ack_sel) begin
      next_rdata = chan_ack[ack_index];
    end else begin
      case (reg_addr)
        `OFF_CTL: next_rdata = {29'h0, mac_reset, mdio_reset, int_enable};
        `OFF_PACE: next_rdata = {15'h0, pace_count};
        `OFF_VECTOR: next_rdata = {12'h0, vector};
        `OFF_SRC_EN: next_rdata = {12'h0, src_enable};
        `OFF_ERR: next_rdata = err_status;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
      rd_stat_q <= 1'b0;
    end else begin
      rd_stat_q <= reg_rd && stat_sel;
      rdata_q <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  assign reg_rdata = rd_stat_q ? stat_rdata : rdata_q;

endmodule
`default_nettype wire

// [verif/dma_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_side_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire intc_pkg::chan_req_t rx_shutdown_cmd,
  input wire intc_pkg::chan_req_t tx_shutdown_cmd,
  output var intc_pkg::chan_req_t rx_shutdown_done,
  output var intc_pkg::chan_req_t tx_shutdown_done
);
  import intc_pkg::*;
  chan_req_t rx_d;
  chan_req_t tx_d;
  // Answers even while the MAC is halted, so the device must do the ignoring
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_d <= '0;
      tx_d <= '0;
      rx_shutdown_done <= '0;
      tx_shutdown_done <= '0;
    end else begin
      rx_d <= rx_shutdown_cmd;
      tx_d <= tx_shutdown_cmd;
      rx_shutdown_done <= rx_d;
      tx_shutdown_done <= tx_d;
    end
  end
endmodule
`default_nettype wire

// [verif/intc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
module intc_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic host_error_event,
  input wire intc_pkg::chan_req_t rx_shutdown_cmd,
  input wire logic mac_reset,
  input wire logic mdio_reset,
  input wire logic mac_halted,
  input wire logic irq_out
);
  import intc_pkg::*;
  logic en;
  logic [16:0] pace;
  wire ctl_wr = reg_wr && reg_addr == `OFF_CTL;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      en <= 1'b0;
      pace <= 17'h0;
    end else begin
      if (ctl_wr) en <= reg_wdata[0];
      if (reg_wr && reg_addr == `OFF_PACE) pace <= reg_wdata[16:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_irq_drop;
    ctl_wr && !reg_wdata[0] |=> !irq_out;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq after disable");
  property p_irq_en;
    irq_out |-> en;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  property p_pace_hold;
    $rose(en) && pace != 17'h0 |-> !irq_out [*4];
  endproperty
  a_pace_hold: assert property (p_pace_hold) else $error("irq before pace");
  property p_vec_top;
    $past(reg_rd && reg_addr == `OFF_VECTOR) |-> reg_rdata[31:20] == 12'h0;
  endproperty
  a_vec_top: assert property (p_vec_top) else $error("vector top bits");
  property p_rx_shut;
    reg_wr && reg_addr == `OFF_RX_SHUT
      |=> rx_shutdown_cmd.valid && rx_shutdown_cmd.chan == $past(reg_wdata[2:0]);
  endproperty
  a_rx_shut: assert property (p_rx_shut) else $error("no shutdown cmd");
  property p_ctl_out;
    ctl_wr |=> mac_reset == $past(reg_wdata[2]) && mdio_reset == $past(reg_wdata[1]);
  endproperty
  a_ctl_out: assert property (p_ctl_out) else $error("reset bits");
  property p_halt_set;
    host_error_event && !mac_reset |=> mac_halted;
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("not halted");
  property p_halt_hold;
    mac_halted && !mac_reset && !(ctl_wr && reg_wdata[2]) |=> mac_halted;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt lost");
endmodule
bind mac_interrupt_combiner_pacing intc_checker i_chk (
  .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .host_error_event, .rx_shutdown_cmd, .mac_reset, .mdio_reset, .mac_halted, .irq_out
);
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
module testbench;
  import intc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic mdio_ev = 1'b0;
  logic link_ev = 1'b0;
  logic herr_ev = 1'b0;
  logic [31:0] err_code = 32'h0;
  chan_event_t rx_ev = '0;
  chan_event_t tx_ev = '0;
  stat_inc_t inc = '0;
  chan_req_t rx_shutdown_cmd, tx_shutdown_cmd, rx_shutdown_done, tx_shutdown_done;
  logic mac_reset, mdio_reset, mac_halted, irq_out;
  logic [31:0] v;
  int miscompares = 0;
  int checks_done = 0;
  initial forever #4 clk_sys = ~clk_sys;
  mac_interrupt_combiner_pacing i_dut (
    .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mdio_access_done_event(mdio_ev), .link_change_event(link_ev),
    .host_error_event(herr_ev), .mac_error_code(err_code),
    .rx_desc_event(rx_ev), .tx_desc_event(tx_ev), .rx_shutdown_done, .tx_shutdown_done,
    .stat_inc(inc), .rx_shutdown_cmd, .tx_shutdown_cmd, .mac_reset, .mdio_reset,
    .mac_halted, .irq_out
  );
  dma_side_model i_model (
    .clk_sys, .nrst, .rx_shutdown_cmd, .tx_shutdown_cmd, .rx_shutdown_done, .tx_shutdown_done
  );
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Strobes drop and one idle edge follows, so no signal is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic irq_is(input logic e);
    #1 chk(32'(irq_out), 32'(e));
    @(posedge clk_sys);
  endtask
  task automatic poll(input logic [7:0] a);
    for (int i = 0; i < 10; i++) begin
      rd(a);
      if (v === `TEARDOWN_CODE) break;
    end
    chk(v, `TEARDOWN_CODE);
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc(`OFF_PACE, 32'h0);
    rdc(`OFF_VECTOR, 32'h0);
    rdc(8'hfc, 32'h0);
    wr(`OFF_SRC_EN, 32'h000f_ffff);
    mdio_ev <= 1'b1;
    link_ev <= 1'b1;
    rx_ev <= '{1'b1, 3'h3, 32'h1234_5670};
    tx_ev <= '{1'b1, 3'h5, 32'h0abc_d000};
    @(posedge clk_sys);
    mdio_ev <= 1'b0;
    link_ev <= 1'b0;
    rx_ev <= '0;
    tx_ev <= '0;
    irq_is(1'b0);
    rdc(`OFF_VECTOR, 32'h000c_2008);
    wr(`OFF_CTL, 32'h1);
    irq_is(1'b1);
    wr(`OFF_PACE, 32'hffff_ffff);
    rdc(`OFF_PACE, 32'h0001_ffff);
    wr(`OFF_PACE, 32'h3);
    // Second round shows that each re-enable restarts the full count
    repeat (2) begin
      wr(`OFF_CTL, 32'h0);
      irq_is(1'b0);
      wr(`OFF_CTL, 32'h1);
      // Count 3 is 12 system cycles: low through the eleventh edge, high at the twelfth
      repeat (11) irq_is(1'b0);
      irq_is(1'b1);
    end
    rdc(8'h2c, 32'h1234_5670);
    wr(8'h2c, 32'h1234_5670);
    rdc(8'h54, 32'h0abc_d000);
    wr(8'h54, 32'h0abc_d000);
    rdc(`OFF_VECTOR, 32'h000c_0000);
    wr(`OFF_VECTOR, 32'h000c_0000);
    irq_is(1'b0);
    wr(`OFF_SRC_EN, 32'h0007_ffff);
    mdio_ev <= 1'b1;
    @(posedge clk_sys);
    mdio_ev <= 1'b0;
    rdc(`OFF_VECTOR, 32'h0);
    irq_is(1'b0);
    wr(`OFF_VECTOR, 32'h0008_0000);
    wr(`OFF_SRC_EN, 32'h000f_ffff);
    inc <= '{1'b1, 4'h2};
    repeat (3) @(posedge clk_sys);
    inc <= '0;
    rdc(8'h88, 32'h3);
    wr(8'h88, 32'h2);
    rdc(8'h88, 32'h1);
    wr(8'h88, 32'h2);
    rdc(`OFF_VECTOR, 32'h0002_0000);
    irq_is(1'b1);
    wr(8'h88, 32'hffff_ffff);
    rdc(`OFF_VECTOR, 32'h0);
    // An increment on the word being decremented must survive the write
    inc <= '{1'b1, 4'h2};
    wr(8'h88, 32'h1);
    inc <= '0;
    rdc(8'h88, 32'h1);
    wr(`OFF_CTL, 32'h0);
    wr(`OFF_RX_SHUT, 32'h1);
    wr(`OFF_TX_SHUT, 32'h6);
    poll(8'h24);
    wr(8'h24, `TEARDOWN_CODE);
    poll(8'h58);
    wr(8'h58, `TEARDOWN_CODE);
    rdc(`OFF_VECTOR, 32'h0);
    err_code <= 32'h0000_0bad;
    herr_ev <= 1'b1;
    @(posedge clk_sys);
    herr_ev <= 1'b0;
    rdc(`OFF_VECTOR, 32'h0001_0000);
    rdc(`OFF_ERR, 32'h0000_0bad);
    chk(32'(mac_halted), 32'h1);
    wr(`OFF_RX_SHUT, 32'h2);
    repeat (6) @(posedge clk_sys);
    rdc(8'h28, 32'h0);
    wr(`OFF_CTL, 32'h4);
    chk(32'(mac_reset), 32'h1);
    rdc(`OFF_VECTOR, 32'h0);
    wr(`OFF_CTL, 32'h2);
    chk(32'(mdio_reset), 32'h1);
    test_done;
  end
endmodule
`default_nettype wire
